// ==== core/tascc_conv_timer.sv ====
// Conversion clock divider and N+4 period conversion timer.
`timescale 1ns/1ps
`include "tascc_defines.svh"
module tascc_conv_timer #(
  parameter int CLK_MHZ = `TASCC_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [1:0] rate_i,
  input wire logic [3:0] bits_i,
  output logic active_o,
  output logic done_o
);

  logic act_q, act_d, done_q, done_d;
  logic [5:0] div_q, div_d;
  logic [4:0] per_q, per_d;
  logic [10:0] cyc_q, cyc_d;

  // System clock cycles in one internal conversion clock period.
  function automatic logic [5:0] div_of(input logic [1:0] rate);
    case (rate)
      2'h0: div_of = 6'(CLK_MHZ / `TASCC_INTCLK_8_MHZ);
      2'h1: div_of = 6'(CLK_MHZ / `TASCC_INTCLK_4_MHZ);
      2'h2: div_of = 6'(CLK_MHZ / `TASCC_INTCLK_2_MHZ);
      default: div_of = 6'(CLK_MHZ / `TASCC_INTCLK_1_MHZ);
    endcase
  endfunction

  always_comb begin
    act_d = act_q;
    div_d = div_q;
    per_d = per_q;
    done_d = 1'b0;
    cyc_d = act_q ? cyc_q + 11'h1 : cyc_q;
    if (abort_i) begin
      act_d = 1'b0;
    end else if (start_i) begin
      act_d = 1'b1;
      div_d = 6'h0;
      per_d = 5'h0;
      cyc_d = 11'h0;
    end else if (act_q) begin
      if (div_q == div_of(rate_i) - 6'h1) begin
        div_d = 6'h0;
        if (per_q == {1'b0, bits_i} + 5'(`TASCC_CONV_EXTRA - 1)) begin
          act_d = 1'b0;
          done_d = 1'b1;
        end else begin
          per_d = per_q + 5'h1;
        end
      end else begin
        div_d = div_q + 6'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      act_q <= 1'b0;
      done_q <= 1'b0;
      div_q <= 6'h0;
      per_q <= 5'h0;
      cyc_q <= 11'h0;
    end else begin
      act_q <= act_d;
      done_q <= done_d;
      div_q <= div_d;
      per_q <= per_d;
      cyc_q <= cyc_d;
    end
  end

  assign active_o = act_q;
  assign done_o = done_q;

  AST_CONV_LENGTH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done_q |-> cyc_q == 11'(div_of(rate_i)) * (11'(bits_i) + 11'(`TASCC_CONV_EXTRA)))
    else $error("Conversion did not last N+4 internal clock periods.");

endmodule

// ==== core/tascc_defines.svh ====
// Constants of the touch converter scan control block.
`ifndef TASCC_DEFINES_SVH
`define TASCC_DEFINES_SVH

// ************************************************************
// System clock and control word
// ************************************************************
`define TASCC_CLK_MHZ 40
`define TASCC_CTRL_RESET 16'h0000
`define TASCC_RD_PEN_BIT 15
`define TASCC_RD_IDLE_BIT 14

// ************************************************************
// Scan selection codes
// ************************************************************
`define TASCC_SCAN_NONE 4'h0
`define TASCC_SCAN_XY 4'h1
`define TASCC_SCAN_XYZ 4'h2
`define TASCC_SCAN_X 4'h3
`define TASCC_SCAN_Y 4'h4
`define TASCC_SCAN_Z 4'h5
`define TASCC_SCAN_BATA 4'h6
`define TASCC_SCAN_BATB 4'h7
`define TASCC_SCAN_AUX 4'h8
`define TASCC_SCAN_AUX_RPT 4'h9
`define TASCC_SCAN_TEMPA 4'ha
`define TASCC_SCAN_PORT 4'hb
`define TASCC_SCAN_TEMPB 4'hc
`define TASCC_SCAN_DRV_X 4'hd
`define TASCC_SCAN_DRV_Y 4'hf

// ************************************************************
// Resolution and conversion timing
// ************************************************************
`define TASCC_RES_8 2'h1
`define TASCC_RES_10 2'h2
`define TASCC_CONV_EXTRA 4
`define TASCC_INTCLK_8_MHZ 8
`define TASCC_INTCLK_4_MHZ 4
`define TASCC_INTCLK_2_MHZ 2
`define TASCC_INTCLK_1_MHZ 1

// ************************************************************
// Panel settling times
// ************************************************************
`define TASCC_SETTLE_100_US 100
`define TASCC_SETTLE_500_US 500
`define TASCC_SETTLE_1_MS 1
`define TASCC_SETTLE_5_MS 5
`define TASCC_SETTLE_10_MS 10
`define TASCC_SETTLE_50_MS 50
`define TASCC_SETTLE_100_MS 100
`define TASCC_US_PER_MS 1000

`endif

// ==== core/tascc_pkg.sv ====
// Types of the touch converter scan control block.
package tascc_pkg;

  typedef struct packed {
    logic self_seq;
    logic stop;
    logic [3:0] scan;
    logic [1:0] res;
    logic [1:0] avg;
    logic [1:0] rate;
    logic [2:0] settle;
    logic filt;
  } tascc_ctrl_t;

  typedef struct packed {
    logic x;
    logic y;
    logic z;
  } tascc_drv_t;

  typedef enum logic [3:0] {
    CH_NONE = 4'h0, CH_X = 4'h1, CH_Y = 4'h2, CH_ZA = 4'h3, CH_ZB = 4'h4,
    CH_BATA = 4'h5, CH_BATB = 4'h6, CH_AUX = 4'h7, CH_TEMPA = 4'h8,
    CH_TEMPB = 4'h9
  } tascc_chan_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_WAIT_PEN = 6'h02, S_SETTLE = 6'h04,
    S_CONV = 6'h08, S_MEDIAN = 6'h10, S_STORE = 6'h20
  } tascc_state_t;

endpackage

// ==== core/tascc_scan_ctrl.sv ====
// Touch converter scan sequencer with its control register.
`timescale 1ns/1ps
`include "tascc_defines.svh"
module tascc_scan_ctrl #(
  parameter int MAX_SAMPLES = 16,
  parameter int SETTLE_500US_CYC = `TASCC_SETTLE_500_US * `TASCC_CLK_MHZ,
  parameter int SETTLE_1MS_CYC = `TASCC_SETTLE_1_MS * `TASCC_US_PER_MS * `TASCC_CLK_MHZ,
  parameter int SETTLE_5MS_CYC = `TASCC_SETTLE_5_MS * `TASCC_US_PER_MS * `TASCC_CLK_MHZ,
  parameter int SETTLE_10MS_CYC = `TASCC_SETTLE_10_MS * `TASCC_US_PER_MS * `TASCC_CLK_MHZ,
  parameter int SETTLE_50MS_CYC = `TASCC_SETTLE_50_MS * `TASCC_US_PER_MS * `TASCC_CLK_MHZ,
  parameter int SETTLE_100MS_CYC = `TASCC_SETTLE_100_MS * `TASCC_US_PER_MS * `TASCC_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ctrl_wr_i,
  input wire logic [15:0] ctrl_wdata_i,
  output logic [15:0] ctrl_rdata_o,
  input wire logic pen_down_i,
  input wire logic [11:0] adc_data_i,
  output tascc_pkg::tascc_drv_t drv_o,
  output tascc_pkg::tascc_chan_t chan_o,
  output logic conv_start_o,
  output logic conv_active_o,
  output logic adc_power_down_o,
  output logic result_wr_o,
  output tascc_pkg::tascc_chan_t result_chan_o,
  output logic [15:0] result_data_o
);

  localparam int SETTLE_100US_CYC = `TASCC_SETTLE_100_US * `TASCC_CLK_MHZ;

  // ************************************************************
  // Decoding functions
  // ************************************************************
  function automatic tascc_pkg::tascc_chan_t first_chan(input logic [3:0] scan);
    case (scan)
      `TASCC_SCAN_XY, `TASCC_SCAN_XYZ, `TASCC_SCAN_X: first_chan = tascc_pkg::CH_X;
      `TASCC_SCAN_Y: first_chan = tascc_pkg::CH_Y;
      `TASCC_SCAN_Z: first_chan = tascc_pkg::CH_ZA;
      `TASCC_SCAN_BATA, `TASCC_SCAN_PORT: first_chan = tascc_pkg::CH_BATA;
      `TASCC_SCAN_BATB: first_chan = tascc_pkg::CH_BATB;
      `TASCC_SCAN_AUX, `TASCC_SCAN_AUX_RPT: first_chan = tascc_pkg::CH_AUX;
      `TASCC_SCAN_TEMPA: first_chan = tascc_pkg::CH_TEMPA;
      `TASCC_SCAN_TEMPB: first_chan = tascc_pkg::CH_TEMPB;
      default: first_chan = tascc_pkg::CH_NONE;
    endcase
  endfunction

  function automatic tascc_pkg::tascc_chan_t next_chan(input logic [3:0] scan,
                                                       input tascc_pkg::tascc_chan_t ch);
    next_chan = tascc_pkg::CH_NONE;
    case (scan)
      `TASCC_SCAN_XY: begin
        if (ch == tascc_pkg::CH_X) next_chan = tascc_pkg::CH_Y;
      end
      `TASCC_SCAN_XYZ: begin
        if (ch == tascc_pkg::CH_X) next_chan = tascc_pkg::CH_Y;
        if (ch == tascc_pkg::CH_Y) next_chan = tascc_pkg::CH_ZA;
        if (ch == tascc_pkg::CH_ZA) next_chan = tascc_pkg::CH_ZB;
      end
      `TASCC_SCAN_Z: begin
        if (ch == tascc_pkg::CH_ZA) next_chan = tascc_pkg::CH_ZB;
      end
      `TASCC_SCAN_PORT: begin
        if (ch == tascc_pkg::CH_BATA) next_chan = tascc_pkg::CH_BATB;
        if (ch == tascc_pkg::CH_BATB) next_chan = tascc_pkg::CH_AUX;
      end
      default: next_chan = tascc_pkg::CH_NONE;
    endcase
  endfunction

  function automatic logic is_touch(input logic [3:0] scan);
    is_touch = (scan >= `TASCC_SCAN_XY) && (scan <= `TASCC_SCAN_Z);
  endfunction

  function automatic logic [3:0] res_bits(input logic [1:0] res);
    case (res)
      `TASCC_RES_8: res_bits = 4'h8;
      `TASCC_RES_10: res_bits = 4'ha;
      default: res_bits = 4'hc;
    endcase
  endfunction

  function automatic logic [4:0] sample_count(input logic [1:0] avg, input logic med);
    case (avg)
      2'h1: sample_count = med ? 5'h05 : 5'h04;
      2'h2: sample_count = med ? 5'h09 : 5'h08;
      2'h3: sample_count = med ? 5'h0f : 5'h10;
      default: sample_count = 5'h01;
    endcase
  endfunction

  function automatic logic [23:0] settle_cyc(input logic [2:0] code);
    case (code)
      3'h1: settle_cyc = 24'(SETTLE_100US_CYC);
      3'h2: settle_cyc = 24'(SETTLE_500US_CYC);
      3'h3: settle_cyc = 24'(SETTLE_1MS_CYC);
      3'h4: settle_cyc = 24'(SETTLE_5MS_CYC);
      3'h5: settle_cyc = 24'(SETTLE_10MS_CYC);
      3'h6: settle_cyc = 24'(SETTLE_50MS_CYC);
      3'h7: settle_cyc = 24'(SETTLE_100MS_CYC);
      default: settle_cyc = 24'h0;
    endcase
  endfunction

  // Narrower results keep the upper converter bits, right-justified.
  function automatic logic [11:0] trim(input logic [11:0] d, input logic [1:0] res);
    case (res)
      `TASCC_RES_8: trim = {4'h0, d[11:4]};
      `TASCC_RES_10: trim = {2'h0, d[11:2]};
      default: trim = d;
    endcase
  endfunction

  // ************************************************************
  // Pen input synchroniser
  // ************************************************************
  logic pen_meta_q, pen_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pen_meta_q <= 1'b0;
      pen_q <= 1'b0;
    end else begin
      pen_meta_q <= pen_down_i;
      pen_q <= pen_meta_q;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  tascc_pkg::tascc_ctrl_t ctrl_q, ctrl_d, wr_ctrl;
  tascc_pkg::tascc_state_t state_q, state_d;
  tascc_pkg::tascc_chan_t chan_q, chan_d, rchan_q, rchan_d, go_chan, nxt;
  tascc_pkg::tascc_drv_t drv_q, drv_d;
  logic [23:0] cnt_q, cnt_d;
  logic [3:0] idx_q, idx_d, med_q, med_d;
  logic [15:0] acc_q, acc_d, rdata_q, rdata_d;
  logic [11:0] samp_q [MAX_SAMPLES];
  logic [11:0] samp_d [MAX_SAMPLES];
  logic [11:0] smp;
  logic [4:0] nsamp, lt, le;
  logic [3:0] shift;
  logic wr_q, wr_d, start_q, start_d, go, tmr_done, tmr_active;

  assign nsamp = sample_count(ctrl_q.avg, ctrl_q.filt);
  assign smp = trim(adc_data_i, ctrl_q.res);
  assign wr_ctrl = tascc_pkg::tascc_ctrl_t'(ctrl_wdata_i);

  always_comb begin
    lt = 5'h0;
    le = 5'h0;
    for (int j = 0; j < MAX_SAMPLES; j++) begin
      if (5'(j) < nsamp) begin
        if (samp_q[j] < samp_q[med_q]) lt = lt + 5'h1;
        if (samp_q[j] <= samp_q[med_q]) le = le + 5'h1;
      end
    end
  end

  always_comb begin
    case (ctrl_q.avg)
      2'h1: shift = 4'h2;
      2'h2: shift = 4'h3;
      2'h3: shift = 4'h4;
      default: shift = 4'h0;
    endcase
  end

  always_comb begin
    ctrl_d = ctrl_q;
    state_d = state_q;
    chan_d = chan_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    med_d = med_q;
    acc_d = acc_q;
    samp_d = samp_q;
    rchan_d = rchan_q;
    rdata_d = rdata_q;
    wr_d = 1'b0;
    start_d = 1'b0;
    go = 1'b0;
    go_chan = first_chan(ctrl_q.scan);
    nxt = next_chan(ctrl_q.scan, chan_q);
    case (state_q)
      tascc_pkg::S_IDLE: begin
        chan_d = tascc_pkg::CH_NONE;
      end
      tascc_pkg::S_WAIT_PEN: begin
        go = pen_q;
      end
      tascc_pkg::S_SETTLE: begin
        if (cnt_q >= settle_cyc(ctrl_q.settle)) begin
          state_d = tascc_pkg::S_CONV;
          start_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 24'h1;
        end
      end
      tascc_pkg::S_CONV: begin
        if (tmr_done) begin
          samp_d[idx_q] = smp;
          acc_d = acc_q + {4'h0, smp};
          if ({1'b0, idx_q} == nsamp - 5'h1) begin
            if (ctrl_q.filt && nsamp != 5'h01) begin
              state_d = tascc_pkg::S_MEDIAN;
              med_d = 4'h0;
            end else begin
              state_d = tascc_pkg::S_STORE;
              rdata_d = acc_d >> shift;
            end
          end else begin
            idx_d = idx_q + 4'h1;
            start_d = 1'b1;
          end
        end
      end
      tascc_pkg::S_MEDIAN: begin
        // The median is the sample with at most k smaller and more than k not larger.
        if (lt <= (nsamp - 5'h1) >> 1 && le > (nsamp - 5'h1) >> 1) begin
          rdata_d = {4'h0, samp_q[med_q]};
          state_d = tascc_pkg::S_STORE;
        end else begin
          med_d = med_q + 4'h1;
        end
      end
      tascc_pkg::S_STORE: begin
        wr_d = 1'b1;
        rchan_d = chan_q;
        if (nxt != tascc_pkg::CH_NONE) begin
          go = 1'b1;
          go_chan = nxt;
        end else if (ctrl_q.scan == `TASCC_SCAN_AUX_RPT) begin
          go = 1'b1;
        end else if ((ctrl_q.scan == `TASCC_SCAN_XY || ctrl_q.scan == `TASCC_SCAN_XYZ)
                     && pen_q) begin
          go = 1'b1;
        end else begin
          state_d = tascc_pkg::S_IDLE;
        end
      end
      default: state_d = tascc_pkg::S_IDLE;
    endcase
    if (ctrl_wr_i) begin
      ctrl_d = wr_ctrl;
      go_chan = first_chan(wr_ctrl.scan);
      go = 1'b0;
      start_d = 1'b0;
      state_d = tascc_pkg::S_IDLE;
      chan_d = tascc_pkg::CH_NONE;
      if (wr_ctrl.stop) begin
        go = 1'b0;
      end else if (go_chan != tascc_pkg::CH_NONE) begin
        if (wr_ctrl.self_seq && is_touch(wr_ctrl.scan)) begin
          state_d = tascc_pkg::S_WAIT_PEN;
        end else begin
          go = 1'b1;
        end
      end
    end
    if (go) begin
      state_d = tascc_pkg::S_SETTLE;
      chan_d = go_chan;
      cnt_d = 24'h0;
      idx_d = 4'h0;
      acc_d = 16'h0;
    end
  end

  // Panel drivers follow the channel being measured or the driver-only codes.
  always_comb begin
    drv_d = '0;
    if (state_d == tascc_pkg::S_SETTLE || state_d == tascc_pkg::S_CONV) begin
      drv_d.x = chan_d == tascc_pkg::CH_X;
      drv_d.y = chan_d == tascc_pkg::CH_Y;
      drv_d.z = chan_d == tascc_pkg::CH_ZA || chan_d == tascc_pkg::CH_ZB;
    end else if (state_d == tascc_pkg::S_IDLE && !ctrl_d.stop) begin
      drv_d.x = ctrl_d.scan == `TASCC_SCAN_DRV_X;
      drv_d.y = ctrl_d.scan == `TASCC_SCAN_DRV_Y;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_q <= tascc_pkg::tascc_ctrl_t'(`TASCC_CTRL_RESET);
      state_q <= tascc_pkg::S_IDLE;
      chan_q <= tascc_pkg::CH_NONE;
      rchan_q <= tascc_pkg::CH_NONE;
      drv_q <= '0;
      cnt_q <= 24'h0;
      idx_q <= 4'h0;
      med_q <= 4'h0;
      acc_q <= 16'h0;
      rdata_q <= 16'h0;
      wr_q <= 1'b0;
      start_q <= 1'b0;
      for (int i = 0; i < MAX_SAMPLES; i++) begin
        samp_q[i] <= 12'h0;
      end
    end else begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      chan_q <= chan_d;
      rchan_q <= rchan_d;
      drv_q <= drv_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      med_q <= med_d;
      acc_q <= acc_d;
      rdata_q <= rdata_d;
      wr_q <= wr_d;
      start_q <= start_d;
      samp_q <= samp_d;
    end
  end

  tascc_conv_timer u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(start_q),
    .abort_i(state_q != tascc_pkg::S_CONV),
    .rate_i(ctrl_q.rate),
    .bits_i(res_bits(ctrl_q.res)),
    .active_o(tmr_active),
    .done_o(tmr_done)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  // Bit 15 reads the pen, bit 14 reads sequencer idle (state S_IDLE); the rest as written.
  assign ctrl_rdata_o = {pen_q, state_q == tascc_pkg::S_IDLE, ctrl_q[13:0]};
  assign drv_o = drv_q;
  assign chan_o = chan_q;
  assign conv_start_o = start_q;
  assign conv_active_o = tmr_active;
  assign adc_power_down_o = ctrl_q.stop;
  assign result_wr_o = wr_q;
  assign result_chan_o = rchan_q;
  assign result_data_o = rdata_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence seq_host_write;
    ctrl_wr_i && !wr_ctrl.stop && !wr_ctrl.self_seq
      && first_chan(wr_ctrl.scan) != tascc_pkg::CH_NONE;
  endsequence

  sequence seq_settle_then_start;
    state_q == tascc_pkg::S_SETTLE ##1 state_q == tascc_pkg::S_CONV && start_q;
  endsequence

  AST_NO_SCAN_IDLE: assert property (
    ctrl_wr_i && wr_ctrl.scan == `TASCC_SCAN_NONE |=> state_q == tascc_pkg::S_IDLE [*2])
    else $error("Scan code zero started a conversion.");

  AST_STOP_HALTS: assert property (
    ctrl_wr_i && wr_ctrl.stop |=> state_q == tascc_pkg::S_IDLE && adc_power_down_o
      ##1 !conv_active_o)
    else $error("Stop did not halt the converter.");

  AST_WRITE_RESTARTS: assert property (
    seq_host_write |=> state_q == tascc_pkg::S_SETTLE && idx_q == 4'h0
      && chan_q == first_chan(ctrl_q.scan))
    else $error("Control write did not restart at the first conversion.");

  AST_ZERO_SETTLE: assert property (
    state_q == tascc_pkg::S_SETTLE && ctrl_q.settle == 3'h0 && !ctrl_wr_i
      |-> ##1 state_q == tascc_pkg::S_CONV ##0 start_q)
    else $error("Zero settling did not start conversion next cycle.");

  AST_SETTLE_BEFORE_CONV: assert property (
    $rose(state_q == tascc_pkg::S_CONV) |-> $past(state_q) == tascc_pkg::S_SETTLE
      && $past(cnt_q) >= settle_cyc(ctrl_q.settle))
    else $error("Conversion began before settling ended.");

  AST_RESULT_WIDTH: assert property (
    result_wr_o && $past(ctrl_q.res) == `TASCC_RES_8 && !$past(ctrl_wr_i)
      |-> result_data_o[15:8] == 8'h00)
    else $error("8-bit result wider than 8 bits.");

  AST_X_ONLY: assert property (
    result_wr_o && ctrl_q.scan == `TASCC_SCAN_X |-> result_chan_o == tascc_pkg::CH_X)
    else $error("X-only scan stored another channel.");

  AST_PEN_LIFT_ENDS: assert property (
    state_q == tascc_pkg::S_STORE && ctrl_q.scan == `TASCC_SCAN_XY && !pen_q
      && chan_q == tascc_pkg::CH_Y && !ctrl_wr_i |=> state_q == tascc_pkg::S_IDLE)
    else $error("Coordinate scan kept running after pen lift.");

  AST_DRIVER_ONLY: assert property (
    ctrl_wr_i && !wr_ctrl.stop && wr_ctrl.scan == `TASCC_SCAN_DRV_X
      |=> drv_o.x && !drv_o.y && state_q == tascc_pkg::S_IDLE ##1 !conv_active_o)
    else $error("Driver-only code misbehaved.");

  AST_CONV_SEQ: assert property (
    seq_settle_then_start |-> ##1 conv_active_o)
    else $error("Conversion timer did not start after settling.");

endmodule

// ==== testbench/tascc_panel_model.sv ====
// Panel and converter model facing the scan control block.
`timescale 1ns/1ps
module tascc_panel_model (
  input wire logic clk_i,
  input wire logic pen_i,
  input wire logic active_i,
  input wire logic [3:0] chan_i,
  output logic pen_o,
  output logic [11:0] adc_o
);
  // Outside a conversion the data churns so that a stale sample shows.
  logic [11:0] churn_q = 12'h000;
  logic hold_q = 1'b0;
  always @(posedge clk_i) begin
    churn_q <= churn_q + 12'h5a5;
    hold_q <= active_i;
  end
  // The result stays valid for the one cycle after the conversion ends.
  assign adc_o = (active_i || hold_q) ? {chan_i, 8'hc3} : churn_q;
  assign pen_o = pen_i;
endmodule

// ==== testbench/tb_tascc_scan_ctrl.sv ====
// Self-checking bench of the touch converter scan control block.
`timescale 1ns/1ps
module tb_tascc_scan_ctrl;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ctrl_wr_i = 1'b0;
  logic [15:0] ctrl_wdata_i = 16'h0000;
  logic pen = 1'b1;
  logic [15:0] ctrl_rdata_o;
  logic pen_down_i;
  logic [11:0] adc_data_i;
  tascc_pkg::tascc_drv_t drv_o;
  tascc_pkg::tascc_chan_t chan_o;
  tascc_pkg::tascc_chan_t result_chan_o;
  logic conv_start_o;
  logic conv_active_o;
  logic adc_power_down_o;
  logic result_wr_o;
  logic [15:0] result_data_o;
  int err_total = 0;
  int n_compared = 0;
  int k;
  always #12.5 clk_i = ~clk_i;
  tascc_scan_ctrl #(.SETTLE_500US_CYC(50), .SETTLE_1MS_CYC(60), .SETTLE_5MS_CYC(70),
    .SETTLE_10MS_CYC(80), .SETTLE_50MS_CYC(90)) u_tascc_scan_ctrl (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
    .ctrl_rdata_o(ctrl_rdata_o), .pen_down_i(pen_down_i), .adc_data_i(adc_data_i),
    .drv_o(drv_o), .chan_o(chan_o), .conv_start_o(conv_start_o),
    .conv_active_o(conv_active_o), .adc_power_down_o(adc_power_down_o),
    .result_wr_o(result_wr_o), .result_chan_o(result_chan_o), .result_data_o(result_data_o));
  tascc_panel_model u_tascc_panel_model (.clk_i(clk_i), .pen_i(pen), .active_i(conv_active_o),
    .chan_i(chan_o), .pen_o(pen_down_i), .adc_o(adc_data_i));
  task automatic close_out();
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] w);
    @(posedge clk_i);
    #1 ctrl_wr_i = 1'b1;
    ctrl_wdata_i = w;
    @(posedge clk_i);
    #1 ctrl_wr_i = 1'b0;
  endtask
  // Waits for one result; act counts busy cycles, lat the cycles since entry.
  task automatic res(input logic [3:0] ch, input logic [1:0] rs, input int act, input int lat);
    int n;
    int a;
    logic [15:0] e;
    n = 0;
    a = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
      if (conv_active_o === 1'b1) a++;
    end while (result_wr_o !== 1'b1 && n < 3000);
    e = (rs == 2'h1) ? {8'h0, ch, 4'hc} : (rs == 2'h2) ? {6'h0, ch, 6'h30} : {4'h0, ch, 8'hc3};
    chk({12'h0, result_chan_o}, {12'h0, ch});
    chk(result_data_o, e);
    chk(a[15:0], act[15:0]);
    if (lat >= 0) chk(n[15:0], lat[15:0]);
  endtask
  task automatic quiet(input int cyc, output int s);
    s = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      #1 if (conv_start_o === 1'b1 || result_wr_o === 1'b1) s++;
    end
  endtask
  task automatic t_rate();
    wr(16'h0e10);
    res(4'h1, 2'h2, 140, 144);
    chk({2'h0, ctrl_rdata_o[13:0]}, 16'h0e10);
    wr(16'h0d30);
    res(4'h1, 2'h1, 480, 484);
  endtask
  task automatic t_once();
    logic [3:0] cd [5] = '{4'h6, 4'h7, 4'h8, 4'ha, 4'hc};
    for (int i = 0; i < 5; i++) begin
      wr({2'h0, cd[i], 10'h0});
      res(4'h5 + i[3:0], 2'h0, 80, 84);
    end
    wr(16'h2c00);
    res(4'h5, 2'h0, 80, 84);
    res(4'h6, 2'h0, 80, -1);
    res(4'h7, 2'h0, 80, -1);
    wr(16'h2400);
    res(4'h7, 2'h0, 80, 84);
    res(4'h7, 2'h0, 80, -1);
  endtask
  task automatic t_scan();
    wr(16'h0500);
    res(4'h1, 2'h1, 60, 64);
    res(4'h2, 2'h1, 60, -1);
    res(4'h1, 2'h1, 60, -1);
    pen = 1'b0;
    res(4'h2, 2'h1, 60, -1);
    quiet(150, k);
    chk(k[15:0], 16'h0);
    pen = 1'b1;
    wr(16'h0900);
    for (int i = 1; i < 5; i++) res(i[3:0], 2'h1, 60, -1);
    wr(16'h1500);
    chk({13'h0, drv_o}, 16'h0001);
    res(4'h3, 2'h1, 60, -1);
    res(4'h4, 2'h1, 60, -1);
  endtask
  task automatic t_misc();
    wr(16'h0dc0);
    res(4'h1, 2'h1, 960, -1);
    wr(16'h0d41);
    res(4'h1, 2'h1, 300, -1);
    wr(16'h0d04);
    res(4'h1, 2'h1, 60, 114);
    wr(16'h0d0c);
    res(4'h1, 2'h1, 60, 154);
    wr(16'h0d00);
    repeat (20) @(posedge clk_i);
    wr(16'h1100);
    res(4'h2, 2'h1, 60, 64);
  endtask
  task automatic t_self();
    pen = 1'b0;
    wr(16'h8d00);
    quiet(40, k);
    chk(k[15:0], 16'h0);
    pen = 1'b1;
    res(4'h1, 2'h1, 60, 67);
  endtask
  task automatic t_stop();
    wr(16'h1800);
    repeat (20) @(posedge clk_i);
    wr(16'h5800);
    chk({15'h0, adc_power_down_o}, 16'h1);
    quiet(150, k);
    chk(k[15:0], 16'h0);
    wr(16'h0000);
    chk({15'h0, adc_power_down_o}, 16'h0);
    quiet(20, k);
    chk(k[15:0], 16'h0);
    wr(16'h3800);
    quiet(150, k);
    chk(k[15:0], 16'h0);
    wr(16'h3400);
    quiet(20, k);
    chk({k[13:0], drv_o.x, drv_o.y}, 16'h2);
    wr(16'h3c00);
    quiet(20, k);
    chk({k[13:0], drv_o.x, drv_o.y}, 16'h1);
  endtask
  initial begin
    #1000000 err_total++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    chk(ctrl_rdata_o, 16'h4000);
    chk({12'h0, chan_o}, 16'h0);
    t_rate();
    t_once();
    t_scan();
    t_misc();
    t_self();
    t_stop();
    close_out();
  end
endmodule
